//--- rtc_counter_tamper_logic.sv
// Real-time counter with tamper detection, APB registers and interrupt
//
// Notes on behaviour
// - Narrow writes to counter or calendar in their active mode are dropped.
// - First counter read after enabling read sync returns a wrong value.
// - Majority debounce bit is stored but does not affect tamper filtering.
// - Enabling the block raises a spurious tamper event flag.
// - External reset during detection blocks the next timestamp capture.
// - Periodic events still fire with prescaler off when tamper features are on.
// - Reading the timestamp leaves the tamper event flag set.
// - Tamper detection clears general purpose store regardless of its enable bit.
// - Disabled, active layer input still detects and stamps, but no flag or id.
module rtc_counter_tamper_logic import rtc_pkg::*; (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire apb_req_s              apb_req,
   output apb_rsp_s                   apb_rsp,
   // Tamper pins and system events
   input  wire logic [NUM_TAMPER-1:0] tamper_in,
   input  wire logic                  ext_reset_seen,
   // Outputs
   output logic                       irq,
   output logic                       tamper_pulse,
   output logic      [PER_BITS-1:0]   periodic_event
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      ctrl_a_s                         ctrl_a;
      ctrl_b_s                         ctrl_b;
      logic [2*NUM_TAMPER-1:0]         tamper_control;
      irq_s                            mask;
      irq_s                            status;
      irq_s                            rd_clear;
      logic [31:0]                     counter;
      logic [31:0]                     calendar;
      logic [31:0]                     timestamp;
      logic [NUM_TAMPER-1:0]           source_id;
      logic [GP_COUNT-1:0][31:0]       gp;
      logic [1:0]                      sync_busy_flags;
      logic                            first_sync_read;
      logic                            ts_blocked;
      logic [NUM_TAMPER-1:0]           level_d;
      logic [31:0]                     prdata;
      logic                            pslverr;
      logic                            irq;
      logic                            tamper_pulse;
   } state_s;

   // Block state outside the filter and prescaler, registered in one place
   state_s st;
   state_s next_st;

   logic [NUM_TAMPER-1:0] level;
   logic                  filt_busy;
   logic                  tick;
   logic [PER_BITS-1:0]   periodic;
   logic                  features_on;

   // ****************************************
   // Decode helpers
   // ****************************************

   // True when an address maps onto a register
   function automatic logic addr_mapped(input logic [7:0] a);
      logic r;

      r = (a[1:0] == 2'h0) && ((a <= OFS_SYNC_BUSY) || (a[7:4] == GP_PAGE));
      return r;
   endfunction

   // Full-width check for timekeeping registers in their active mode
   function automatic logic wide_ok(input counter_mode_e m, input logic is_cal,
                                    input logic [3:0] strb);
      logic r;
      // Other modes accept any strobe pattern
      r = 1'b1;

      if (!is_cal && m == MODE_WIDE) begin
         r = (strb == STROBE_FULL);
      end else if (!is_cal && m == MODE_HALF) begin
         r = (strb[1:0] == 2'h3);
      end else if (is_cal && m == MODE_CALENDAR) begin
         r = (strb == STROBE_FULL);
      end
      return r;
   endfunction

   // ****************************************
   // Submodules
   // ****************************************
   assign features_on = (st.tamper_control != '0) || st.ctrl_b.debounce_enable;

   // Majority option is not wired into the filter
   rtc_tamper_filter u_filter (
      .pclk            (pclk),
      .presetn         (presetn),
      .raw             (tamper_in),
      .debounce_enable (st.ctrl_b.debounce_enable),
      .level           (level),
      .busy            (filt_busy)
   );

   rtc_prescaler u_prescaler (
      .pclk        (pclk),
      .presetn     (presetn),
      .run         (st.ctrl_a.enable),
      .features_on (features_on),
      .prescaler   (st.ctrl_a.prescaler),
      .tick        (tick),
      .periodic    (periodic)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic                  setup;
      logic                  access;
      logic                  do_wr;
      logic [7:0]            a;
      logic [NUM_TAMPER-1:0] rise;
      logic [NUM_TAMPER-1:0] armed;
      logic [NUM_TAMPER-1:0] flagged;
      logic                  detect_any;
      logic                  flag_set;
      logic                  spurious;
      logic                  ovf;
      logic [31:0]           w;
      irq_s                  ev;
      ctrl_a_s               na;

      next_st = st;
      setup   = apb_req.psel && !apb_req.penable;
      access  = apb_req.psel && apb_req.penable;
      do_wr   = access && apb_req.pwrite && !st.pslverr;
      a       = apb_req.paddr;
      w       = RESET_WORD;
      ovf     = 1'b0;
      na      = st.ctrl_a;
      detect_any = 1'b0;
      flag_set   = 1'b0;
      spurious   = 1'b0;
      ev         = IRQ_RESET;

      // Tamper edge detection on filtered levels
      next_st.level_d = level;
      rise  = level & ~st.level_d;
      armed = '0;
      flagged = '0;

      for (int i = 0; i < NUM_TAMPER; i++) begin
         if (st.ctrl_a.enable) begin
            armed[i]   = st.tamper_control[2*i +: 2] != ACT_OFF;
            flagged[i] = armed[i];
         end else begin
            // Active layer keeps detecting while disabled, but unflagged
            armed[i] = st.tamper_control[2*i +: 2] == ACT_ACTIVE_LAYER;
         end
      end
      detect_any = |(rise & armed);

      // Timekeeping advance
      if (st.ctrl_a.enable && tick) begin
         unique case (st.ctrl_a.mode)
            MODE_WIDE: begin
               next_st.counter = st.counter + 32'h1;
               ovf = (st.counter == 32'hffff_ffff);
            end
            MODE_HALF: begin
               next_st.counter = {16'h0, st.counter[15:0] + 16'h1};
               ovf = (st.counter[15:0] == 16'hffff);
            end
            MODE_CALENDAR: begin
               next_st.calendar = st.calendar + 32'h1;
               ovf = (st.calendar == 32'hffff_ffff);
            end
            MODE_RESERVED: begin
               ovf = 1'b0;
            end
         endcase
      end

      // APB setup phase: latch read data and error, so outputs come from flops
      next_st.rd_clear = IRQ_RESET;

      if (setup) begin
         next_st.pslverr = !addr_mapped(a);
         next_st.prdata  = RESET_WORD;
         if (!apb_req.pwrite) begin
            if (a[7:4] == GP_PAGE) begin
               next_st.prdata = st.gp[a[3:2]];
            end else begin
               unique case (a)
                  OFS_CTRL_A:         next_st.prdata = {24'h0, st.ctrl_a};
                  OFS_CTRL_B:         next_st.prdata = {29'h0, st.ctrl_b};
                  OFS_TAMPER_CONTROL: next_st.prdata = {24'h0, st.tamper_control};
                  OFS_INT_MASK:       next_st.prdata = {29'h0, st.mask};
                  OFS_INT_STATUS: begin
                     next_st.prdata   = {29'h0, st.status};
                     next_st.rd_clear = st.status;
                  end
                  OFS_COUNTER: begin
                     // First synced value is stale: zero is shown once
                     if (st.ctrl_a.count_read_sync_enable && st.first_sync_read) begin
                        next_st.prdata          = RESET_WORD;
                        next_st.first_sync_read = 1'b0;
                     end else begin
                        next_st.prdata = st.counter;
                     end
                  end
                  OFS_CALENDAR:       next_st.prdata = st.calendar;
                  // Timestamp read has no side effect on the flag
                  OFS_TIMESTAMP:      next_st.prdata = st.timestamp;
                  OFS_SOURCE_ID:      next_st.prdata = {28'h0, st.source_id};
                  OFS_SYNC_BUSY:      next_st.prdata = {30'h0, st.sync_busy_flags};
                  default:            next_st.prdata = RESET_WORD;
               endcase
            end
         end
      end

      // APB access phase: writes take effect here
      // Busy lasts one cycle
      next_st.sync_busy_flags = 2'h0;

      if (do_wr) begin
         if (a[7:4] == GP_PAGE) begin
            next_st.gp[a[3:2]] = merge_bytes(st.gp[a[3:2]], apb_req.pwdata, apb_req.pstrb);
         end else begin
            unique case (a)
               OFS_CTRL_A: begin
                  w  = merge_bytes({24'h0, st.ctrl_a}, apb_req.pwdata, apb_req.pstrb);
                  na = ctrl_a_s'(w[7:0]);
                  next_st.ctrl_a = na;
                  next_st.sync_busy_flags = {na.count_read_sync_enable !=
                                             st.ctrl_a.count_read_sync_enable,
                                             na.enable != st.ctrl_a.enable};
                  if (na.count_read_sync_enable && !st.ctrl_a.count_read_sync_enable) begin
                     next_st.first_sync_read = 1'b1;
                  end
               end
               OFS_CTRL_B: begin
                  w = merge_bytes({29'h0, st.ctrl_b}, apb_req.pwdata, apb_req.pstrb);
                  next_st.ctrl_b = ctrl_b_s'(w[2:0]);
               end
               OFS_TAMPER_CONTROL: begin
                  w = merge_bytes({24'h0, st.tamper_control}, apb_req.pwdata, apb_req.pstrb);
                  next_st.tamper_control = w[7:0];
               end
               OFS_INT_MASK: begin
                  w = merge_bytes({29'h0, st.mask}, apb_req.pwdata, apb_req.pstrb);
                  next_st.mask = irq_s'(w[2:0]);
               end
               OFS_COUNTER: begin
                  // Narrow writes in the active counting mode are lost
                  if (wide_ok(st.ctrl_a.mode, 1'b0, apb_req.pstrb)) begin
                     next_st.counter = merge_bytes(st.counter, apb_req.pwdata, apb_req.pstrb);
                  end
               end
               OFS_CALENDAR: begin
                  if (wide_ok(st.ctrl_a.mode, 1'b1, apb_req.pstrb)) begin
                     next_st.calendar = merge_bytes(st.calendar, apb_req.pwdata,
                                                    apb_req.pstrb);
                  end
               end
               default: begin
                  w = RESET_WORD;
               end
            endcase
         end
      end

      // Enabling the block shows a false tamper
      spurious = next_st.ctrl_a.enable && !st.ctrl_a.enable;
      flag_set = spurious || (|(rise & flagged));

      // Tamper consequences
      if (detect_any) begin
         for (int g = 0; g < GP_COUNT; g++) begin
            next_st.gp[g] = RESET_WORD; // Store enable bit ignored
         end

         if (st.ts_blocked) begin
            next_st.ts_blocked = 1'b0; // Capture lost once
         end else begin
            next_st.timestamp = (st.ctrl_a.mode == MODE_CALENDAR) ? st.calendar : st.counter;
         end

         if (|(rise & flagged)) begin
            next_st.source_id = st.source_id | (rise & flagged);
         end
      end

      // Reset seen while a detection is settling poisons the next capture
      if (ext_reset_seen && (filt_busy || (|(rise & armed)))) begin
         next_st.ts_blocked = 1'b1;
      end
      next_st.tamper_pulse = detect_any;

      // Sticky status: set wins over read-clear
      ev.tamper_event_flag = flag_set;
      ev.periodic          = |periodic;
      ev.overflow          = ovf;

      next_st.status = (st.status & ~st.rd_clear) | ev;
      next_st.irq    = |(next_st.status & next_st.mask);
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Answer always comes in the access phase, one cycle after setup
   assign apb_rsp.prdata  = st.prdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = st.pslverr && apb_req.psel && apb_req.penable;

   // Registered outputs
   assign irq             = st.irq;
   assign tamper_pulse    = st.tamper_pulse;
   assign periodic_event  = periodic;

endmodule

//--- rtc_pkg.sv
// Shared constants, register map and carrier types of the real-time counter block
package rtc_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_TAMPER = 4;
   localparam int GP_COUNT   = 4;
   localparam int PER_BITS   = 8;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CTRL_A         = 8'h00;
   localparam logic [7:0] OFS_CTRL_B         = 8'h04;
   localparam logic [7:0] OFS_TAMPER_CONTROL = 8'h08;
   localparam logic [7:0] OFS_INT_MASK       = 8'h0c;
   localparam logic [7:0] OFS_INT_STATUS     = 8'h10;
   localparam logic [7:0] OFS_COUNTER        = 8'h14;
   localparam logic [7:0] OFS_CALENDAR       = 8'h18;
   localparam logic [7:0] OFS_TIMESTAMP      = 8'h1c;
   localparam logic [7:0] OFS_SOURCE_ID      = 8'h20;
   localparam logic [7:0] OFS_SYNC_BUSY      = 8'h24;
   localparam logic [3:0] GP_PAGE            = 4'h3;

   // ****************************************
   // Field values and counts
   // ****************************************
   localparam logic [1:0]  ACT_OFF          = 2'h0;
   localparam logic [1:0]  ACT_ACTIVE_LAYER = 2'h3;
   localparam logic [1:0]  DEBOUNCE_COUNT   = 2'h3;
   localparam logic [3:0]  PRESCALER_OFF    = 4'h0;
   localparam logic [3:0]  STROBE_FULL      = 4'hf;
   localparam logic [31:0] RESET_WORD       = 32'h0;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {MODE_WIDE, MODE_HALF, MODE_CALENDAR, MODE_RESERVED} counter_mode_e;

   typedef struct packed {
      logic          count_read_sync_enable;
      logic [3:0]    prescaler;
      counter_mode_e mode;
      logic          enable;
   } ctrl_a_s;

   typedef struct packed {
      logic store_reset_on_tamper_enable;
      logic debounce_enable;
      logic majority_debounce_enable;
   } ctrl_b_s;

   typedef struct packed {
      logic overflow;
      logic periodic;
      logic tamper_event_flag;
   } irq_s;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   localparam ctrl_a_s CTRL_A_RESET = '0;
   localparam ctrl_b_s CTRL_B_RESET = '0;
   localparam irq_s    IRQ_RESET    = '0;

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wdata,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

//--- rtc_tamper_filter.sv
// Tamper pin synchroniser and stability debouncer
module rtc_tamper_filter import rtc_pkg::*; (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // Pins and control
   input  wire logic [NUM_TAMPER-1:0] raw,
   input  wire logic                  debounce_enable,
   // Filtered result
   output logic      [NUM_TAMPER-1:0] level,
   output logic                       busy
);

   typedef struct packed {
      logic [NUM_TAMPER-1:0]      sync1;
      logic [NUM_TAMPER-1:0]      sync2;
      logic [NUM_TAMPER-1:0]      level;
      logic [NUM_TAMPER-1:0][1:0] cnt;
   } filt_s;

   filt_s st;
   filt_s next_st;

   // Two-stage sync, then a level must differ for a run of samples to be taken
   always_comb begin
      next_st = st;
      next_st.sync1 = raw;
      next_st.sync2 = st.sync1;
      for (int i = 0; i < NUM_TAMPER; i++) begin
         if (!debounce_enable) begin
            next_st.level[i] = st.sync2[i];
            next_st.cnt[i]   = 2'h0;
         end else if (st.sync2[i] == st.level[i]) begin
            next_st.cnt[i] = 2'h0;
         end else if (st.cnt[i] == DEBOUNCE_COUNT - 2'h1) begin
            next_st.level[i] = st.sync2[i];
            next_st.cnt[i]   = 2'h0;
         end else begin
            next_st.cnt[i] = st.cnt[i] + 2'h1;
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;
   assign busy  = |st.cnt; // A pending change counts as detection in progress

endmodule

//--- rtc_prescaler.sv
// Prescaler divider with counter tick and periodic event pulses
module rtc_prescaler import rtc_pkg::*; (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Control
   input  wire logic                run,
   input  wire logic                features_on,
   input  wire logic [3:0]          prescaler,
   // Pulses
   output logic                     tick,
   output logic      [PER_BITS-1:0] periodic
);

   typedef struct packed {
      logic [15:0]         div;
      logic                tick;
      logic [PER_BITS-1:0] periodic;
   } pre_s;

   pre_s st;
   pre_s next_st;

   // Tick every 2^prescaler cycles; periodic bit i on each wrap of div[i:0], none while prescaler and tamper features are both off
   always_comb begin
      logic [15:0] mask;
      logic [15:0] pm;
      mask = 16'((32'h1 << prescaler) - 32'h1);
      pm   = 16'h0;
      next_st     = st;
      next_st.div = run ? st.div + 16'h1 : 16'h0;
      next_st.tick = run && ((st.div & mask) == mask);
      for (int i = 0; i < PER_BITS; i++) begin
         pm = 16'((32'h2 << i) - 32'h1);
         // Prescaler off still fires periodics once tamper features are on
         next_st.periodic[i] = run && ((st.div & pm) == pm) &&
                               ((prescaler != PRESCALER_OFF) || features_on);
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick     = st.tick;
   assign periodic = st.periodic;

endmodule

//--- rtc_counter_tamper_logic_checker.sv
// Port-level assertions of the real-time counter block
module rtc_counter_tamper_logic_checker import rtc_pkg::*; (
   // Clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // Watched ports
   input wire apb_req_s              apb_req,
   input wire apb_rsp_s              apb_rsp,
   input wire logic [NUM_TAMPER-1:0] tamper_in,
   input wire logic                  irq,
   input wire logic                  tamper_pulse,
   input wire logic [PER_BITS-1:0]   periodic_event
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ****************************************
   // Sequences and assertions
   // ****************************************
   // Access phase, and a timestamp read while the interrupt is up
   sequence s_access;
      apb_req.psel && apb_req.penable;
   endsequence
   sequence s_stamp_read;
      s_access ##0 (!apb_req.pwrite && apb_req.paddr == OFS_TIMESTAMP && irq);
   endsequence

   a_ready_held: assert property (apb_req.psel |-> apb_rsp.pready)
      else $error("pready low in a transfer");
   a_err_phase: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
      else $error("pslverr outside access phase");
   a_unmapped_err: assert property (s_access ##0 apb_req.paddr == 8'h28 |-> apb_rsp.pslverr)
      else $error("no error on unmapped address");
   a_mapped_ok: assert property (s_access ##0 apb_req.paddr == OFS_COUNTER |-> !apb_rsp.pslverr)
      else $error("error on counter access");
   a_pulse_single: assert property (tamper_pulse |=> !tamper_pulse)
      else $error("tamper pulse longer than one cycle");
   a_pulse_cause: assert property (tamper_pulse |-> $past(tamper_in, 4) != '0)
      else $error("tamper pulse without a pin");
   a_period_pulse: assert property (periodic_event[0] |=> !periodic_event[0])
      else $error("periodic bit 0 not a pulse");
   a_stamp_keeps: assert property (s_stamp_read |=> irq ##1 irq)
      else $error("timestamp read dropped the interrupt");
endmodule

bind rtc_counter_tamper_logic rtc_counter_tamper_logic_checker rtc_counter_tamper_logic_checker_i (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .tamper_in(tamper_in),
   .irq(irq), .tamper_pulse(tamper_pulse), .periodic_event(periodic_event));

//--- rtc_counter_tamper_logic_tb.sv
// Self-checking testbench of the real-time counter block
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module rtc_counter_tamper_logic_tb import rtc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   apb_req_s              req = '0;
   apb_rsp_s              rsp;
   logic [NUM_TAMPER-1:0] tamper_in = '0;
   logic                  ext_reset_seen = 1'b0;
   logic                  irq;
   logic                  tamper_pulse;
   logic [PER_BITS-1:0]   periodic_event;
   int                    failures = 0;
   int                    cmp_count = 0;
   int                    cyc = 0;
   logic [31:0]           rd;
   logic [31:0]           t0;
   logic                  err;
   logic                  seen;

   // 20 MHz clock
   always #25 pclk = ~pclk;

   rtc_counter_tamper_logic rtc_counter_tamper_logic_i (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .tamper_in(tamper_in),
      .ext_reset_seen(ext_reset_seen), .irq(irq), .tamper_pulse(tamper_pulse),
      .periodic_event(periodic_event));

   // ****************************************
   // Bus and watch tasks
   // ****************************************
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d, pstrb: s};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1) @(posedge pclk);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, STROBE_FULL);
   endtask
   task automatic rdr(input logic [7:0] a);
      apb(a, 1'b0, 32'h0, 4'h0);
   endtask
   // Sampled at the falling edge, where registered outputs have settled
   task automatic watch(input int n, input logic per);
      seen = 1'b0;
      repeat (n) begin
         @(negedge pclk);
         if ((per ? (periodic_event != '0) : tamper_pulse) === 1'b1) seen = 1'b1;
      end
   endtask
   // Pin change launched just after a rising edge
   task automatic pins(input logic [NUM_TAMPER-1:0] v);
      @(posedge pclk);
      tamper_in <= v;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      rdr(OFS_CTRL_A);
      `CHK("ctrl_a reset", RESET_WORD, rd)
      rdr(OFS_INT_STATUS);
      `CHK("status reset", RESET_WORD, rd)
      rdr(8'h28);
      `CHK("unmapped error", 1'b1, err)
   endtask
   task automatic t_narrow();
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_COUNTER, 32'h12345678);
      apb(OFS_COUNTER, 1'b1, 32'h000000aa, 4'h1);
      apb(OFS_COUNTER, 1'b1, 32'h0000aaaa, 4'h3);
      rdr(OFS_COUNTER);
      `CHK("wide narrow write", 32'h12345678, rd)
      wr(OFS_CTRL_A, 32'h2);
      apb(OFS_COUNTER, 1'b1, 32'h000000aa, 4'h1);
      rdr(OFS_COUNTER);
      `CHK("half byte write", 16'h5678, rd[15:0])
      wr(OFS_CTRL_A, 32'h4);
      wr(OFS_CALENDAR, 32'hcafe0001);
      apb(OFS_CALENDAR, 1'b1, 32'h12340000, 4'hc);
      rdr(OFS_CALENDAR);
      `CHK("calendar half write", 32'hcafe0001, rd)
   endtask
   // Only the flag is unmasked, so periodic status never reaches irq
   task automatic t_flag();
      wr(OFS_INT_MASK, 32'h1);
      wr(OFS_CTRL_A, 32'h79);
      watch(2, 1'b0);
      `CHK("irq on enable", 1'b1, irq)
      rdr(OFS_INT_STATUS);
      `CHK("spurious flag", 1'b1, rd[0])
      wr(OFS_INT_MASK, 32'h0);
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_CTRL_A, 32'h79);
      watch(2, 1'b0);
      `CHK("irq masked", 1'b0, irq)
      wr(OFS_INT_MASK, 32'h1);
      watch(2, 1'b0);
      `CHK("irq unmasked", 1'b1, irq)
      rdr(OFS_INT_STATUS);
      watch(2, 1'b0);
      `CHK("irq cleared", 1'b0, irq)
   endtask
   task automatic t_sync();
      wr(OFS_CTRL_A, 32'h81);
      rdr(OFS_SYNC_BUSY);
      `CHK("busy cleared", 32'h0, rd)
      rdr(OFS_COUNTER);
      `CHK("first synced read", 32'h0, rd)
      rdr(OFS_COUNTER);
      `CHK("second synced read", 1'b1, rd != 32'h0)
   endtask
   // Majority bit set, debounce off: the plain latency must hold
   task automatic t_tamper();
      wr({GP_PAGE, 4'h0}, 32'ha5a5a5a5);
      wr(OFS_CTRL_B, 32'h1);
      wr(OFS_TAMPER_CONTROL, 32'h1);
      pins(4'h1);
      watch(6, 1'b0);
      `CHK("majority no delay", 1'b1, seen)
      rdr({GP_PAGE, 4'h0});
      `CHK("store cleared", 32'h0, rd)
      rdr(OFS_TIMESTAMP);
      rdr(OFS_INT_STATUS);
      `CHK("flag after stamp read", 1'b1, rd[0])
      rdr(OFS_SOURCE_ID);
      `CHK("source id", 1'b1, rd[0])
      pins(4'h0);
   endtask
   // Reset pulse lands inside the debounce window of a running detection
   task automatic t_extrst();
      wr(OFS_CTRL_B, 32'h2);
      rdr(OFS_TIMESTAMP);
      t0 = rd;
      pins(4'h1);
      repeat (4) @(posedge pclk);
      ext_reset_seen <= 1'b1;
      @(posedge pclk);
      ext_reset_seen <= 1'b0;
      watch(12, 1'b0);
      rdr(OFS_TIMESTAMP);
      `CHK("stamp skipped", t0, rd)
      pins(4'h0);
      repeat (8) @(posedge pclk);
      pins(4'h1);
      watch(12, 1'b0);
      rdr(OFS_TIMESTAMP);
      `CHK("stamp resumed", 1'b1, rd != t0)
      pins(4'h0);
   endtask
   task automatic t_layer();
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_CTRL_B, 32'h0);
      wr(OFS_TAMPER_CONTROL, 32'h30);
      rdr(OFS_INT_STATUS);
      pins(4'h4);
      watch(12, 1'b0);
      `CHK("disabled detection", 1'b1, seen)
      rdr(OFS_INT_STATUS);
      `CHK("no flag disabled", 1'b0, rd[0])
      rdr(OFS_SOURCE_ID);
      `CHK("no id disabled", 1'b0, rd[2])
      pins(4'h0);
   endtask
   task automatic t_presc();
      wr(OFS_TAMPER_CONTROL, 32'h0);
      wr(OFS_CTRL_A, 32'h1);
      watch(16, 1'b1);
      `CHK("periodic off", 1'b0, seen)
      wr(OFS_TAMPER_CONTROL, 32'h40);
      watch(16, 1'b1);
      `CHK("periodic with tamper", 1'b1, seen)
   endtask

   // ****************************************
   // Run control
   // ****************************************
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Hang guard, well beyond the length of the sequence
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_narrow();
      t_flag();
      t_sync();
      t_tamper();
      t_extrst();
      t_layer();
      t_presc();
      conclude();
   end
endmodule
